// [hw/flash_read_pkg.sv]
package flash_read_pkg;
	// array read command codes
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_FAST = 8'h0B;
	localparam logic [7:0] CMD_DUAL_OUT = 8'h3B;
	localparam logic [7:0] CMD_DUAL_IO = 8'hBB;
	localparam logic [7:0] CMD_QUAD_OUT = 8'h6B;
	localparam logic [7:0] CMD_QUAD_IO = 8'hEB;

	// lane counts
	localparam logic [2:0] LANES1 = 3'h1;
	localparam logic [2:0] LANES2 = 3'h2;
	localparam logic [2:0] LANES4 = 3'h4;

	// clocks per phase
	localparam logic [4:0] CMD_CLKS_SPI = 5'h08;
	localparam logic [4:0] CMD_CLKS_QPI = 5'h02;
	localparam logic [4:0] ADDR_CLKS_X1 = 5'h18;
	localparam logic [4:0] ADDR_CLKS_X2 = 5'h0C;
	localparam logic [4:0] ADDR_CLKS_X4 = 5'h06;
	localparam logic [4:0] FAST_DUMMY = 5'h08;
	localparam logic [4:0] DUAL_IO_DUMMY = 5'h04;
	localparam logic [4:0] QUAD_IO_DUMMY = 5'h06;
	localparam logic [4:0] DUAL_MODE_CLKS = 5'h04;
	localparam logic [4:0] QUAD_MODE_CLKS = 5'h02;
	localparam logic [4:0] CNT_ONE = 5'h01;

	// dummy clocks in quad-command mode, by read_dummy_select_bits
	localparam logic [4:0] QPI_DUMMY_SEL0 = 5'h08;
	localparam logic [4:0] QPI_DUMMY_SEL1 = 5'h06;
	localparam logic [4:0] QPI_DUMMY_SEL2 = 5'h04;
	localparam logic [4:0] QPI_DUMMY_SEL3 = 5'h02;

	// continuous mode byte field
	localparam int MODE_SEL_LSB = 4;
	localparam logic [1:0] CONT_KEEP = 2'h2;

	// byte and wrap geometry
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [23:0] WRAP_MIN = 24'h000008;
	localparam logic [23:0] ADDR_ONE = 24'h000001;
	localparam logic [23:0] ADDR_ALL = 24'hFFFFFF;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CMD = 3'b001,
		ST_ADDR = 3'b010,
		ST_MODE = 3'b011,
		ST_DUMMY = 3'b100,
		ST_DATA = 3'b101,
		ST_IGNORE = 3'b110
	} phase_t;

	typedef struct packed {
		logic data_line_three;
		logic data_line_two;
		logic data_line_one;
		logic data_line_zero;
	} quad_lines_t;

	typedef struct packed {
		logic ok;
		logic wrap_ok;
		logic [2:0] addr_lanes;
		logic [2:0] data_lanes;
		logic [4:0] addr_clks;
		logic [4:0] mode_clks;
		logic [4:0] dummy_clks;
	} read_cfg_t;
endpackage

// [hw/byte_fifo.sv]
`timescale 1ns/10ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic flush_in,
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in
);
	import flash_read_pkg::*;
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
		$error("byte_fifo depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic rdy_q, rdy_d, push, pop;

	// ready is registered so the source never sees a combinational path
	always_comb begin
		mem_d = mem_q;
		push = in_valid_in && rdy_q && !flush_in;
		pop = out_ready_in && (cnt_q != '0) && !flush_in;
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (flush_in) begin
			wr_d = '0;
			rd_d = '0;
			cnt_d = '0;
		end else begin
			if (push) begin
				mem_d[wr_q] = in_data_in;
				wr_d = wr_q + 1'b1;
			end
			if (pop) begin
				rd_d = rd_q + 1'b1;
			end
			cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
		rdy_d = !flush_in && (cnt_d < (AW + 1)'(DEPTH));
	end

	// storage carries no reset, only the pointers, count and ready flag do
	always_ff @(posedge clk_in) begin
		mem_q <= mem_d;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			rdy_q <= 1'b0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			rdy_q <= rdy_d;
		end
	end

	assign in_ready_out = rdy_q;
	assign out_valid_out = (cnt_q != '0);
	assign out_data_out = mem_q[rd_q];
endmodule

// [hw/flash_read_engine.sv]
`timescale 1ns/10ps
// Behaviour
// - read 03: single-line command, address, falling-edge data
// - address increments after every byte fetched from the array
// - reads ignored while internal cycle busy
// - fast read: eight dummy clocks before data
// - quad-command dummy clocks chosen by select bits
// - quad-command fast read never wraps
// - dual output: single-line in, two-line out
// - dual io: two-line address, mode, no dummies
// - mode bits 10 skip next dual command
// - other mode bits leave continuous mode
// - quad output: single-line in, four-line out
// - quad io accepted only with quad enable
// - quad io: four-line address, mode, four dummies
// - mode bits 10 skip next quad command
// - wrap confines quad io to aligned section
// - quad-command quad io: mode counts as dummy
// - quad-command quad io ignores wrap
module flash_read_engine #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire flash_read_pkg::quad_lines_t data_lines_in,
	output flash_read_pkg::quad_lines_t data_lines_out,
	output flash_read_pkg::quad_lines_t data_lines_oe_out,
	input wire logic cycle_busy_in,
	input wire logic quad_enable_bit_in,
	input wire logic quad_command_mode_in,
	input wire logic [1:0] read_dummy_select_bits_in,
	input wire logic wrap_enable_in,
	input wire logic [1:0] wrap_len_in,
	output logic [23:0] mem_addr_out,
	output logic mem_ready_out,
	input wire logic mem_valid_in,
	input wire logic [7:0] mem_data_in,
	output logic continuous_mode_out
);
	import flash_read_pkg::*;

	if (FIFO_DEPTH < 2) begin : g_fifo_chk
		$error("FIFO_DEPTH must be at least 2");
	end

	function automatic logic [4:0] qpi_dummy(input logic [1:0] sel);
		case (sel)
			2'h0: qpi_dummy = QPI_DUMMY_SEL0;
			2'h1: qpi_dummy = QPI_DUMMY_SEL1;
			2'h2: qpi_dummy = QPI_DUMMY_SEL2;
			default: qpi_dummy = QPI_DUMMY_SEL3;
		endcase
	endfunction

	function automatic read_cfg_t decode(input logic [7:0] c, input logic quad_command_mode, input logic qe,
		input logic [1:0] p);
		read_cfg_t r;
		r = '0;
		r.ok = 1'b1;
		r.addr_lanes = quad_command_mode ? LANES4 : LANES1;
		r.data_lanes = quad_command_mode ? LANES4 : LANES1;
		case (c)
			CMD_READ: r.ok = !quad_command_mode;
			CMD_FAST: r.dummy_clks = quad_command_mode ? qpi_dummy(p) : FAST_DUMMY;
			CMD_DUAL_OUT: begin
				r.ok = !quad_command_mode;
				r.data_lanes = LANES2;
				r.dummy_clks = FAST_DUMMY;
			end
			CMD_QUAD_OUT: begin
				r.ok = !quad_command_mode;
				r.data_lanes = LANES4;
				r.dummy_clks = FAST_DUMMY;
			end
			CMD_DUAL_IO: begin
				r.ok = !quad_command_mode;
				r.addr_lanes = LANES2;
				r.data_lanes = LANES2;
				r.mode_clks = DUAL_MODE_CLKS;
				r.dummy_clks = DUAL_IO_DUMMY - DUAL_MODE_CLKS;
			end
			CMD_QUAD_IO: begin
				r.ok = qe;
				r.addr_lanes = LANES4;
				r.data_lanes = LANES4;
				r.mode_clks = QUAD_MODE_CLKS;
				r.dummy_clks = (quad_command_mode ? qpi_dummy(p) : QUAD_IO_DUMMY) - QUAD_MODE_CLKS;
				r.wrap_ok = !quad_command_mode;
			end
			default: r.ok = 1'b0;
		endcase
		case (r.addr_lanes)
			LANES2: r.addr_clks = ADDR_CLKS_X2;
			LANES4: r.addr_clks = ADDR_CLKS_X4;
			default: r.addr_clks = ADDR_CLKS_X1;
		endcase
		return r;
	endfunction

	function automatic logic [23:0] shift_in(input logic [23:0] s, input logic [2:0] lanes,
		input quad_lines_t l);
		case (lanes)
			LANES2: shift_in = {s[21:0], l.data_line_one, l.data_line_zero};
			LANES4: shift_in = {s[19:0], l};
			default: shift_in = {s[22:0], l.data_line_zero};
		endcase
	endfunction

	// top bits of a byte onto the active lanes
	function automatic quad_lines_t drive_lines(input logic [7:0] b, input logic [2:0] lanes);
		quad_lines_t o;
		o = '0;
		case (lanes)
			LANES2: {o.data_line_one, o.data_line_zero} = b[7:6];
			LANES4: o = b[7:4];
			default: o.data_line_one = b[7];
		endcase
		return o;
	endfunction

	function automatic logic [23:0] next_addr(input logic [23:0] a, input logic w,
		input logic [1:0] len);
		logic [23:0] m;
		m = w ? ((WRAP_MIN << len) - ADDR_ONE) : ADDR_ALL;
		return (a & ~m) | ((a + ADDR_ONE) & m);
	endfunction

	// reset release and pin synchronisers
	logic [1:0] rst_s_q;
	logic rst_n;
	logic [2:0] sclk_s_q;
	logic [1:0] cs_s_q;
	quad_lines_t lines_s1_q, lines_s2_q;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_s_q <= 2'h0;
		end else begin
			rst_s_q <= {rst_s_q[0], 1'b1};
		end
	end
	assign rst_n = rst_s_q[1];

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			sclk_s_q <= 3'h0;
			cs_s_q <= 2'h3;
			lines_s1_q <= '0;
			lines_s2_q <= '0;
		end else begin
			sclk_s_q <= {sclk_s_q[1:0], sclk_in};
			cs_s_q <= {cs_s_q[0], cs_n_in};
			lines_s1_q <= data_lines_in;
			lines_s2_q <= lines_s1_q;
		end
	end

	logic rise, fall, cs_hi;
	assign rise = sclk_s_q[1] && !sclk_s_q[2];
	assign fall = !sclk_s_q[1] && sclk_s_q[2];
	assign cs_hi = cs_s_q[1];

	phase_t state_q, state_d;
	logic [4:0] cnt_q, cnt_d;
	logic [23:0] sr_q, sr_d, sr_in, faddr_q, faddr_d;
	read_cfg_t cfg_q, cfg_d, cfg_new;
	logic cont_q, cont_d, fetch_q, fetch_d, wrap_q, wrap_d;
	logic [1:0] wlen_q, wlen_d;
	logic [7:0] sh_q, sh_d, cur;
	logic [3:0] left_q, left_d;
	quad_lines_t out_q, out_d, oe_q, oe_d;
	logic [2:0] lanes_in;
	logic last, pop, hs, fifo_ready, fifo_valid;
	logic [7:0] fifo_data;
	phase_t post_state;
	logic [4:0] post_cnt;

	assign hs = mem_valid_in && fifo_ready && fetch_q;

	// staging buffer between array fetch and serial output
	byte_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.flush_in(!fetch_q),
		.in_valid_in(mem_valid_in && fetch_q),
		.in_data_in(mem_data_in),
		.in_ready_out(fifo_ready),
		.out_valid_out(fifo_valid),
		.out_data_out(fifo_data),
		.out_ready_in(pop)
	);

	// sequencer: moves out of command, address, mode and dummy happen on detected sclk rises; idle moves on without an edge
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		sr_d = sr_q;
		cfg_d = cfg_q;
		cont_d = cont_q;
		fetch_d = fetch_q;
		faddr_d = faddr_q;
		wrap_d = wrap_q;
		wlen_d = wlen_q;
		sh_d = sh_q;
		left_d = left_q;
		out_d = out_q;
		oe_d = oe_q;
		pop = 1'b0;
		cur = sh_q;
		lanes_in = (state_q == ST_CMD) ? (quad_command_mode_in ? LANES4 : LANES1)
			: cfg_q.addr_lanes;
		sr_in = shift_in(sr_q, lanes_in, lines_s2_q);
		cfg_new = decode(sr_in[7:0], quad_command_mode_in, quad_enable_bit_in,
			read_dummy_select_bits_in);
		last = (cnt_q == CNT_ONE);
		post_state = (cfg_q.dummy_clks != '0) ? ST_DUMMY : ST_DATA;
		post_cnt = cfg_q.dummy_clks;
		if (hs) begin
			faddr_d = next_addr(faddr_q, wrap_q, wlen_q);
		end
		if (cs_hi) begin
			state_d = ST_IDLE;
			fetch_d = 1'b0;
			oe_d = '0;
			out_d = '0;
			left_d = '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (cont_q) begin
						state_d = cycle_busy_in ? ST_IGNORE : ST_ADDR;
						cnt_d = cfg_q.addr_clks;
					end else begin
						state_d = ST_CMD;
						cnt_d = quad_command_mode_in ? CMD_CLKS_QPI : CMD_CLKS_SPI;
					end
				end
				ST_CMD: if (rise) begin
					sr_d = sr_in;
					cnt_d = cnt_q - CNT_ONE;
					if (last) begin
						if (!cfg_new.ok || cycle_busy_in) begin
							state_d = ST_IGNORE;
						end else begin
							cfg_d = cfg_new;
							state_d = ST_ADDR;
							cnt_d = cfg_new.addr_clks;
						end
					end
				end
				ST_ADDR: if (rise) begin
					sr_d = sr_in;
					cnt_d = cnt_q - CNT_ONE;
					if (last) begin
						fetch_d = 1'b1;
						faddr_d = sr_in;
						wrap_d = cfg_q.wrap_ok && wrap_enable_in;
						wlen_d = wrap_len_in;
						state_d = (cfg_q.mode_clks != '0) ? ST_MODE : post_state;
						cnt_d = (cfg_q.mode_clks != '0) ? cfg_q.mode_clks : post_cnt;
					end
				end
				ST_MODE: if (rise) begin
					sr_d = sr_in;
					cnt_d = cnt_q - CNT_ONE;
					if (last) begin
						// mode byte decides if the next read skips its command
						cont_d = (sr_in[MODE_SEL_LSB +: 2] == CONT_KEEP);
						state_d = post_state;
						cnt_d = post_cnt;
					end
				end
				ST_DUMMY: if (rise) begin
					cnt_d = cnt_q - CNT_ONE;
					if (last) begin
						state_d = ST_DATA;
					end
				end
				ST_DATA: if (fall) begin
					// lanes turn on only here, after the host let go
					if (left_q == '0) begin
						pop = 1'b1;
						cur = fifo_data;
						oe_d = drive_lines(8'hFF, cfg_q.data_lanes);
					end
					out_d = drive_lines(cur, cfg_q.data_lanes);
					sh_d = 8'(cur << cfg_q.data_lanes);
					left_d = ((left_q == '0) ? BYTE_BITS : left_q) - {1'b0, cfg_q.data_lanes};
				end
				ST_IGNORE: state_d = ST_IGNORE;
				default: state_d = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			sr_q <= '0;
			cfg_q <= '0;
			cont_q <= 1'b0;
			fetch_q <= 1'b0;
			faddr_q <= '0;
			wrap_q <= 1'b0;
			wlen_q <= '0;
			sh_q <= '0;
			left_q <= '0;
			out_q <= '0;
			oe_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			sr_q <= sr_d;
			cfg_q <= cfg_d;
			cont_q <= cont_d;
			fetch_q <= fetch_d;
			faddr_q <= faddr_d;
			wrap_q <= wrap_d;
			wlen_q <= wlen_d;
			sh_q <= sh_d;
			left_q <= left_d;
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end

	assign data_lines_out = out_q;
	assign data_lines_oe_out = oe_q;
	assign mem_addr_out = faddr_q;
	assign mem_ready_out = fifo_ready;
	assign continuous_mode_out = cont_q;

	property p_release_on_cs;
		@(posedge clk_in) disable iff (!rst_n)
		$rose(cs_hi) |-> ##1 (oe_q == '0 && state_q == ST_IDLE) [*2];
	endproperty
	a_release_on_cs: assert property (p_release_on_cs)
		else $error("lines still driven after chip select rose");

	property p_busy_ignored;
		@(posedge clk_in) disable iff (!rst_n)
		(state_q == ST_CMD && rise && last && cycle_busy_in && !cs_hi)
			|=> state_q == ST_IGNORE ##1 !fetch_q;
	endproperty
	a_busy_ignored: assert property (p_busy_ignored)
		else $error("read accepted while internal cycle busy");

	property p_quad_needs_enable;
		@(posedge clk_in) disable iff (!rst_n)
		(state_q == ST_CMD && rise && last && !cs_hi && sr_in[7:0] == CMD_QUAD_IO
			&& !quad_enable_bit_in) |=> state_q == ST_IGNORE;
	endproperty
	a_quad_needs_enable: assert property (p_quad_needs_enable)
		else $error("quad io read accepted without quad enable");

	property p_linear_increment;
		@(posedge clk_in) disable iff (!rst_n)
		(hs && !wrap_q && !cs_hi && state_q != ST_ADDR) |=> faddr_q == $past(faddr_q) + ADDR_ONE;
	endproperty
	a_linear_increment: assert property (p_linear_increment)
		else $error("read address did not step by one");

	property p_wrap_section;
		@(posedge clk_in) disable iff (!rst_n)
		(hs && wrap_q && !cs_hi && state_q != ST_ADDR) |=>
			((faddr_q ^ $past(faddr_q)) & ~((WRAP_MIN << wlen_q) - ADDR_ONE)) == '0;
	endproperty
	a_wrap_section: assert property (p_wrap_section)
		else $error("wrapped read left its aligned section");

	property p_qpi_no_wrap;
		@(posedge clk_in) disable iff (!rst_n)
		(state_q == ST_ADDR && rise && last && !cs_hi && quad_command_mode_in) |=> !wrap_q;
	endproperty
	a_qpi_no_wrap: assert property (p_qpi_no_wrap)
		else $error("wrap active for a quad-command read");

	property p_mode_select;
		@(posedge clk_in) disable iff (!rst_n)
		(state_q == ST_MODE && rise && last && !cs_hi)
			|=> cont_q == (sr_q[MODE_SEL_LSB +: 2] == CONT_KEEP);
	endproperty
	a_mode_select: assert property (p_mode_select)
		else $error("continuous mode not taken from mode byte");

	property p_dummy_count;
		@(posedge clk_in) disable iff (!rst_n)
		(state_q == ST_ADDR && rise && last && !cs_hi && cfg_q.mode_clks == '0
			&& cfg_q.dummy_clks != '0) |=> state_q == ST_DUMMY && cnt_q == (quad_command_mode_in
			? QPI_DUMMY_SEL0 - {2'h0, read_dummy_select_bits_in, 1'b0} : FAST_DUMMY);
	endproperty
	a_dummy_count: assert property (p_dummy_count)
		else $error("wrong dummy clock count loaded");

	property p_msb_first;
		@(posedge clk_in) disable iff (!rst_n)
		(state_q == ST_DATA && fall && !cs_hi && left_q == '0 && cfg_q.data_lanes == LANES1)
			|=> out_q.data_line_one == $past(fifo_data[7]);
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("byte did not start with its top bit");

	property p_drive_only_data;
		@(posedge clk_in) disable iff (!rst_n)
		(oe_q != '0) |-> state_q == ST_DATA;
	endproperty
	a_drive_only_data: assert property (p_drive_only_data)
		else $error("data lines driven outside the data phase");
endmodule

// [sim/flash_host_model.sv]
`timescale 1ns/10ps
module flash_host_model
	import flash_read_pkg::*;
(
	input wire flash_read_pkg::quad_lines_t dev_val_in,
	input wire flash_read_pkg::quad_lines_t dev_oe_in,
	output logic sclk_out,
	output logic cs_n_out,
	output flash_read_pkg::quad_lines_t wire_out,
	output logic [7:0] rx_byte_out,
	output logic [15:0] rx_count_out
);
	logic [3:0] drv_val;
	logic [3:0] drv_en;

	// a released line shows the inverse of its last level, so stale bits never pass
	always_comb begin
		wire_out = (dev_oe_in & dev_val_in) | (~dev_oe_in & drv_en & drv_val)
			| (~dev_oe_in & ~drv_en & ~drv_val);
	end

	// idle: clock low, select high, nothing driven
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		drv_val = 4'h0;
		drv_en = 4'h0;
		rx_byte_out = 8'h00;
		rx_count_out = 16'h0000;
	end

	// one serial clock; the clock only runs inside a frame
	task automatic tick();
		#100 sclk_out = 1'b1;
		#100 sclk_out = 1'b0;
	endtask

	// msb first, ln lanes per clock, new bits right after each fall
	task automatic send(input logic [23:0] v, input int nb, input int ln);
		for (int i = 1; i <= nb / ln; i++) begin
			drv_en = 4'((1 << ln) - 1);
			drv_val = 4'(v >> (nb - ln * i)) & drv_en;
			tick();
		end
	endtask

	// one read frame; bits sampled just before each fall, when they are settled
	task automatic xfer(input logic [7:0] cmd, input int cl, input logic [23:0] a, input int al,
		input int ml, input logic [7:0] m, input int dm, input int dl, input int dclk);
		logic [7:0] acc;
		int n;
		acc = 8'h00;
		n = 0;
		cs_n_out = 1'b0;
		if (cl != 0) send({16'h0000, cmd}, 8, cl);
		send(a, 24, al);
		if (ml != 0) send({16'h0000, m}, 8, ml);
		drv_en = 4'h0;
		repeat (dm) tick();
		for (int i = 0; i < dclk; i++) begin
			#100 sclk_out = 1'b1;
			#95;
			if (dl == 1) acc = {acc[6:0], wire_out[1]};
			else if (dl == 2) acc = {acc[5:0], wire_out[1:0]};
			else acc = {acc[3:0], wire_out};
			n = n + dl;
			if (n == 8) begin
				rx_byte_out = acc;
				rx_count_out = rx_count_out + 16'h0001;
				n = 0;
			end
			#5 sclk_out = 1'b0;
		end
		// a partial byte is dropped when select rises mid-byte
		#50 cs_n_out = 1'b1;
		#300;
	endtask
endmodule

// [sim/serial_flash_array_read_engine_tb_top.sv]
`timescale 1ns/10ps
module serial_flash_array_read_engine_tb_top;
	import flash_read_pkg::*;
	logic clk_in;
	logic arst_n_in;
	logic busy;
	logic quad_en;
	logic quad_cmd;
	logic wrap_en;
	logic mem_valid;
	logic [1:0] dsel;
	logic [1:0] wlen;
	logic [7:0] mem_data;
	logic [23:0] mem_addr;
	logic mem_ready;
	logic cont_mode;
	logic sclk;
	logic cs_n;
	logic drove;
	quad_lines_t lines;
	quad_lines_t dev_val;
	quad_lines_t dev_oe;
	logic [7:0] rx_byte;
	logic [15:0] rx_count;
	logic [7:0] exp_q[$];
	logic [31:0] seed;
	logic [23:0] a;
	int mismatches;
	int check_count;
	int cycles;

	flash_read_engine #(.FIFO_DEPTH(8)) dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.sclk_in(sclk), .cs_n_in(cs_n), .data_lines_in(lines), .data_lines_out(dev_val),
		.data_lines_oe_out(dev_oe), .cycle_busy_in(busy), .quad_enable_bit_in(quad_en),
		.quad_command_mode_in(quad_cmd), .read_dummy_select_bits_in(dsel),
		.wrap_enable_in(wrap_en), .wrap_len_in(wlen), .mem_addr_out(mem_addr),
		.mem_ready_out(mem_ready), .mem_valid_in(mem_valid), .mem_data_in(mem_data),
		.continuous_mode_out(cont_mode));

	flash_host_model host (.dev_val_in(dev_val), .dev_oe_in(dev_oe), .sclk_out(sclk),
		.cs_n_out(cs_n), .wire_out(lines), .rx_byte_out(rx_byte), .rx_count_out(rx_count));

	function automatic logic [7:0] pat(input logic [23:0] x);
		return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'hA5;
	endfunction

	function automatic logic [23:0] lfsr();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h00000000);
		return seed[23:0];
	endfunction

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("mismatches %0d check_count %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// config changes land on the falling edge
	task automatic cfg(input logic b, input logic q, input logic p, input logic [1:0] ds,
		input logic w, input logic [1:0] wl);
		@(negedge clk_in);
		busy = b;
		quad_en = q;
		quad_cmd = p;
		dsel = ds;
		wrap_en = w;
		wlen = wl;
	endtask

	// notes the expected bytes, wrapped inside an aligned section when wl is set
	task automatic rd(input logic [7:0] cmd, input int cl, input logic [23:0] ad, input int al,
		input int ml, input logic [7:0] m, input int dm, input int dl, input int nb, input int wl);
		logic [23:0] x;
		for (int k = 0; k < nb; k++) begin
			x = ad + 24'(k);
			if (wl != 0) x = (ad & ~24'(wl - 1)) | (x & 24'(wl - 1));
			exp_q.push_back(pat(x));
		end
		@(negedge clk_in);
		host.xfer(cmd, cl, ad, al, ml, m, dm, dl, nb * 8 / dl);
	endtask

	// a refused read must never drive a line; seven clocks keep any byte from landing
	task automatic no_drive(input logic [7:0] cmd, input int al, input int ml, input int dm);
		@(negedge clk_in);
		drove = 1'b0;
		host.xfer(cmd, 1, lfsr(), al, ml, 8'h00, dm, 1, 7);
		cmp_bit(drove, 1'b0);
	endtask

	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end

	// array source answers on the falling edge for the address now shown
	always @(negedge clk_in) begin
		mem_valid <= mem_ready;
		mem_data <= pat(mem_addr);
	end

	// hang ceiling and line-drive watch, off the edge opposite the one that launches the enables
	always @(negedge clk_in) begin
		cycles++;
		if (dev_oe !== 4'h0) drove = 1'b1;
		if (cycles == 60000) begin
			mismatches++;
			wrap_up();
		end
	end

	// an unexpected byte is forced to mismatch
	always @(rx_count) begin
		if (rx_count != 16'h0000) begin
			if (exp_q.size() == 0) exp_q.push_back(~rx_byte);
			cmp_byte(rx_byte, exp_q.pop_front());
		end
	end

	initial begin
		arst_n_in = 1'b0;
		busy = 1'b0;
		quad_en = 1'b0;
		quad_cmd = 1'b0;
		wrap_en = 1'b0;
		dsel = 2'h0;
		wlen = 2'h0;
		mem_valid = 1'b0;
		mem_data = 8'h00;
		drove = 1'b0;
		seed = 32'h66381481;
		repeat (5) @(negedge clk_in);
		arst_n_in = 1'b1;
		repeat (8) @(negedge clk_in);
		rd(CMD_READ, 1, lfsr(), 1, 0, 8'h00, 0, 1, 3, 0);
		a = lfsr();
		exp_q.push_back(pat(a));
		@(negedge clk_in);
		host.xfer(CMD_READ, 1, a, 1, 0, 8'h00, 0, 1, 12);
		cmp_byte(8'(dev_oe), 8'h00);
		rd(CMD_FAST, 1, 24'hFFFFFE, 1, 0, 8'h00, 8, 1, 3, 0);
		rd(CMD_DUAL_OUT, 1, lfsr(), 1, 0, 8'h00, 8, 2, 3, 0);
		rd(CMD_QUAD_OUT, 1, lfsr(), 1, 0, 8'h00, 8, 4, 3, 0);
		no_drive(CMD_QUAD_IO, 4, 4, 4);
		cfg(1'b1, 1'b1, 1'b0, 2'h0, 1'b0, 2'h0);
		no_drive(CMD_READ, 1, 0, 0);
		cfg(1'b0, 1'b1, 1'b0, 2'h0, 1'b0, 2'h0);
		rd(CMD_DUAL_IO, 1, lfsr(), 2, 2, 8'h20, 0, 2, 2, 0);
		cmp_bit(cont_mode, 1'b1);
		rd(8'h00, 0, lfsr(), 2, 2, 8'h30, 0, 2, 2, 0);
		cmp_bit(cont_mode, 1'b0);
		rd(CMD_DUAL_IO, 1, lfsr(), 2, 2, 8'h00, 0, 2, 2, 0);
		rd(CMD_QUAD_IO, 1, lfsr(), 4, 4, 8'hA5, 4, 4, 2, 0);
		cmp_bit(cont_mode, 1'b1);
		rd(8'h00, 0, lfsr(), 4, 4, 8'h10, 4, 4, 2, 0);
		cmp_bit(cont_mode, 1'b0);
		// start two bytes before each section end so every length wraps
		for (int w = 0; w < 4; w++) begin
			cfg(1'b0, 1'b1, 1'b0, 2'h0, 1'b1, 2'(w));
			a = lfsr() & ~24'((8 << w) - 1) | 24'((8 << w) - 2);
			rd(CMD_QUAD_IO, 1, a, 4, 4, 8'h00, 4, 4, 4, 8 << w);
		end
		// wrap stays on here, so any wrapping would show
		for (int s = 0; s < 4; s++) begin
			cfg(1'b0, 1'b1, 1'b1, 2'(s), 1'b1, 2'h0);
			a = lfsr() | 24'h000006;
			rd(CMD_FAST, 4, a, 4, 0, 8'h00, 8 - 2 * s, 4, 3, 0);
			rd(CMD_QUAD_IO, 4, a, 4, 4, 8'h20, 6 - 2 * s, 4, 3, 0);
			rd(8'h00, 0, lfsr(), 4, 4, 8'h00, 6 - 2 * s, 4, 2, 0);
		end
		repeat (40) @(negedge clk_in);
		cmp_byte(8'(exp_q.size()), 8'h00);
		wrap_up();
	end
endmodule
